// >>> pwm_load.sv
// Load model: measures run lengths of each pin level in clocks
`timescale 1ns/1ns
module pwm_load (
    input  wire logic        clk,
    input  wire logic        main_output,
    input  wire logic        partner_output,
    output logic      [15:0] m_lo,
    output logic      [15:0] m_hi,
    output logic      [15:0] p_lo,
    output logic      [15:0] p_hi
);
    logic [15:0] mc = 16'h0000;
    logic [15:0] pc = 16'h0000;
    logic        mq = 1'h0;
    logic        pq = 1'h0;
    always @(posedge clk) begin
        mc <= (main_output == mq) ? mc + 16'h0001 : 16'h0001;
        pc <= (partner_output == pq) ? pc + 16'h0001 : 16'h0001;
        if (main_output != mq && mq) m_hi <= mc;
        if (main_output != mq && !mq) m_lo <= mc;
        if (partner_output != pq && pq) p_hi <= pc;
        if (partner_output != pq && !pq) p_lo <= pc;
        mq <= main_output;
        pq <= partner_output;
    end
endmodule

// >>> pwm_pair.sv
// PWM pair generator: 12-bit period, duty and dead time, complementary or independent
`timescale 1ns/1ns
// Function
// - Polarity 10: main output active low, partner active high, both modes.
// - Polarity 11: both outputs active low, both modes.
// - Period is 12 bits: 4-bit high field over 8-bit low field.
// - Upper nibble of every high register reads zero, writes ignored.
// - Only a period low write commits a new period.
// - Committed period applies from next counter overflow.
// - Output period equals period value times prescaled clock cycles.
// - Duty is 12 bits: 4-bit high field over 8-bit low field.
// - Duty follows same high-then-low commit, applying next period.
// - Independent mode: main active time equals duty value times prescaled clock cycles.
// - Dead time is 12 bits: 4-bit high over 8-bit low field.
// - Complementary dead gap lasts dead-time value prescaled cycles.
// - Independent mode: dead-time register sets partner active time.
// - Independent mode: one shared counter, separate duties.
// - Mode bit clear selects complementary, set selects independent.
// - Prescale select divides oscillator by 1, 8, 32 or 128.
// - Enable restarts counter from 1; disable stops and blanks outputs.
// - Each overflow sets the flag; software clears by writing zero.
module pwm_pair (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    // Register port
    input  wire logic [3:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Pins
    output logic                      main_output,
    output logic                      partner_output,
    output logic                      overflow_flag
);

    pwm_pair_pkg::pwm_state_s st_r;
    pwm_pair_pkg::pwm_state_s st_nxt;
    pwm_pair_pkg::reg_req_s   req;

    logic       module_enable;
    logic       pair_mode_select;
    logic [1:0] polarity_select;
    logic [1:0] prescale_select;
    logic       main_oe;
    logic       part_oe;
    logic       tick;
    logic       overflow;
    logic [6:0] div_max;
    logic       main_phase;
    logic       part_phase;

    // Active level mapping for a polarity bit (1 means active low)
    function automatic logic drive_level(input logic active, input logic active_low);
        drive_level = active ^ active_low;
    endfunction

    // Joins a high nibble and a low byte into a 12-bit value
    function automatic logic [11:0] join12(input logic [3:0] hi, input logic [7:0] lo);
        join12 = {hi, lo};
    endfunction

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    // Mode selection bits
    assign module_enable    = st_r.enable[pwm_pair_pkg::EN_MODULE_BIT];
    assign main_oe          = st_r.enable[pwm_pair_pkg::EN_MAIN_OE_BIT];
    assign part_oe          = st_r.enable[pwm_pair_pkg::EN_PART_OE_BIT];
    assign pair_mode_select = st_r.enable[pwm_pair_pkg::EN_MODE_BIT];
    assign polarity_select  = st_r.control[pwm_pair_pkg::CT_POL_LSB +: 2];
    assign prescale_select  = st_r.control[pwm_pair_pkg::CT_PRESC_LSB +: 2];

    always_comb begin
        case (prescale_select)
            2'd0:    div_max = pwm_pair_pkg::DIV_1;
            2'd1:    div_max = pwm_pair_pkg::DIV_8;
            2'd2:    div_max = pwm_pair_pkg::DIV_32;
            2'd3:    div_max = pwm_pair_pkg::DIV_128;
            default: div_max = pwm_pair_pkg::DIV_1;
        endcase
    end

    assign tick = module_enable && (st_r.presc >= div_max);
    assign overflow = tick && (st_r.count >= st_r.shadow.period);

    assign main_phase = (st_r.count <= st_r.shadow.duty) && (st_r.count != 12'h000);
    assign part_phase = (st_r.count <= st_r.shadow.deadtime) && (st_r.count != 12'h000);

    always_comb begin
        st_nxt = st_r;

        // Register writes
        if (req.wr) begin
            case (req.addr)
                pwm_pair_pkg::OFS_ENABLE: begin
                    st_nxt.enable = req.wdata & pwm_pair_pkg::EN_WR_MASK;
                end
                pwm_pair_pkg::OFS_CONTROL: begin
                    st_nxt.control = req.wdata & pwm_pair_pkg::CT_WR_MASK;
                    st_nxt.control[pwm_pair_pkg::CT_FLAG_BIT] =
                        st_r.control[pwm_pair_pkg::CT_FLAG_BIT]
                        & req.wdata[pwm_pair_pkg::CT_FLAG_BIT];
                end
                pwm_pair_pkg::OFS_PERIOD_LOW: begin
                    st_nxt.period_low  = req.wdata;
                    st_nxt.pend.period = join12(st_r.period_high, req.wdata);
                end
                pwm_pair_pkg::OFS_PERIOD_HIGH: begin
                    st_nxt.period_high = req.wdata[3:0];
                end
                pwm_pair_pkg::OFS_DUTY_LOW: begin
                    st_nxt.duty_low  = req.wdata;
                    st_nxt.pend.duty = join12(st_r.duty_high, req.wdata);
                end
                pwm_pair_pkg::OFS_DUTY_HIGH: begin
                    st_nxt.duty_high = req.wdata[3:0];
                end
                pwm_pair_pkg::OFS_DEADTIME_LOW: begin
                    st_nxt.deadtime_low  = req.wdata;
                    st_nxt.pend.deadtime = join12(st_r.deadtime_high, req.wdata);
                end
                pwm_pair_pkg::OFS_DEADTIME_HIGH: begin
                    st_nxt.deadtime_high = req.wdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // Enable rising restarts count from 1
        if (!module_enable) begin
            st_nxt.presc    = 7'h00;
            st_nxt.count    = pwm_pair_pkg::CNT_START;
            st_nxt.gap      = 12'h000;
            st_nxt.main_act = 1'b0;
            st_nxt.part_act = 1'b0;
            // Shadows track commits while stopped so a fresh start uses them
            st_nxt.shadow   = st_nxt.pend;
            st_nxt.prev_phase = 1'b0;
        end else begin
            if (tick) begin
                st_nxt.presc = 7'h00;
                if (overflow) begin
                    st_nxt.count = pwm_pair_pkg::CNT_START;
                    st_nxt.shadow = st_r.pend;
                    st_nxt.control[pwm_pair_pkg::CT_FLAG_BIT] = 1'b1;
                end else begin
                    st_nxt.count = st_r.count + 12'h001;
                end
            end else begin
                st_nxt.presc = st_r.presc + 7'h01;
            end

            // Mode bit picks independent or complementary
            if (pair_mode_select) begin
                st_nxt.main_act = main_phase;
                st_nxt.part_act = part_phase;
                st_nxt.gap      = 12'h000;
            end else begin
                // Phase edge starts the dead gap
                st_nxt.prev_phase = main_phase;
                if (main_phase != st_r.prev_phase) begin
                    st_nxt.main_act = 1'b0;
                    st_nxt.part_act = 1'b0;
                    st_nxt.gap      = st_r.shadow.deadtime;
                    // Zero dead time switches straight over
                    if (st_r.shadow.deadtime == 12'h000) begin
                        st_nxt.main_act = main_phase;
                        st_nxt.part_act = !main_phase;
                    end
                end else if (st_r.gap != 12'h000) begin
                    if (tick) begin
                        st_nxt.gap = st_r.gap - 12'h001;
                        // Last gap tick turns the next output on
                        if (st_r.gap == 12'h001) begin
                            st_nxt.main_act = main_phase;
                            st_nxt.part_act = !main_phase;
                        end
                    end
                end else begin
                    st_nxt.main_act = main_phase;
                    st_nxt.part_act = !main_phase;
                end
            end
        end

        // Read data, one cycle later
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                pwm_pair_pkg::OFS_ENABLE:        st_nxt.rdata = st_r.enable;
                pwm_pair_pkg::OFS_CONTROL:       st_nxt.rdata = st_r.control;
                pwm_pair_pkg::OFS_PERIOD_LOW:    st_nxt.rdata = st_r.period_low;
                pwm_pair_pkg::OFS_PERIOD_HIGH:   st_nxt.rdata = {4'h0, st_r.period_high};
                pwm_pair_pkg::OFS_DUTY_LOW:      st_nxt.rdata = st_r.duty_low;
                pwm_pair_pkg::OFS_DUTY_HIGH:     st_nxt.rdata = {4'h0, st_r.duty_high};
                pwm_pair_pkg::OFS_DEADTIME_LOW:  st_nxt.rdata = st_r.deadtime_low;
                pwm_pair_pkg::OFS_DEADTIME_HIGH: st_nxt.rdata = {4'h0, st_r.deadtime_high};
                default:                         st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Polarity per output; off state is the inactive level
    assign main_output    = drive_level(st_r.main_act && main_oe && module_enable,
                                        polarity_select[1]);
    assign partner_output = drive_level(st_r.part_act && part_oe && module_enable,
                                        polarity_select[0]);
    assign overflow_flag  = st_r.control[pwm_pair_pkg::CT_FLAG_BIT];
    assign reg_rdata      = st_r.rdata;

endmodule

// >>> pwm_pair_assertions.sv
// Checker for the PWM pair register port and pins
`timescale 1ns/1ns
module pwm_pair_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       clk_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       main_output,
    input wire logic       partner_output,
    input wire logic       overflow_flag
);
    logic [2:0] en_r;
    logic [1:0] pol_r;
    // Shadow copies of enable and polarity for the pin checks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_r  <= 3'h0;
            pol_r <= 2'h0;
        end else if (clk_en && reg_wr && reg_addr == pwm_pair_pkg::OFS_ENABLE) begin
            en_r <= reg_wdata[2:0];
        end else if (clk_en && reg_wr && reg_addr == pwm_pair_pkg::OFS_CONTROL) begin
            pol_r <= reg_wdata[3:2];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_hi_wr; reg_wr && reg_addr == pwm_pair_pkg::OFS_PERIOD_HIGH; endsequence
    sequence s_hi_rd; reg_rd && reg_addr == pwm_pair_pkg::OFS_PERIOD_HIGH; endsequence
    property p_rd_idle; !reg_rd && clk_en |=> reg_rdata == 8'h00; endproperty
    property p_hi_read; reg_rd && reg_addr[0] && !reg_addr[3] && reg_addr != 4'h1
        |=> reg_rdata[7:4] == 4'h0; endproperty
    property p_unmapped; reg_rd && reg_addr[3] |=> reg_rdata == 8'h00; endproperty
    property p_hi_wr_rd; s_hi_wr ##1 s_hi_rd |=> reg_rdata == (8'h0F & $past(reg_wdata, 2));
    endproperty
    property p_flag_clear; $fell(overflow_flag) |-> $past(reg_wr)
        && $past(reg_addr) == pwm_pair_pkg::OFS_CONTROL; endproperty
    property p_flag_rise; $rose(overflow_flag) |-> en_r[0]; endproperty
    property p_main_off; !(en_r[0] && en_r[1]) |-> main_output == pol_r[1]; endproperty
    property p_part_off; !(en_r[0] && en_r[2]) |-> partner_output == pol_r[0]; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle read data not zero");
    a_hi_read: assert property (p_hi_read) else $error("high nibble not zero");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hi_wr_rd: assert property (p_hi_wr_rd) else $error("period high readback wrong");
    a_flag_clear: assert property (p_flag_clear) else $error("flag fell without write");
    a_flag_rise: assert property (p_flag_rise) else $error("flag set while off");
    a_main_off: assert property (p_main_off) else $error("main pin not idle");
    a_part_off: assert property (p_part_off) else $error("partner pin not idle");
endmodule
bind pwm_pair pwm_pair_checker chk (.clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .main_output, .partner_output, .overflow_flag);

// >>> pwm_pair_pkg.sv
// Package with register map, field layout and types of the PWM pair generator
package pwm_pair_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] OFS_ENABLE        = 4'h0;
    localparam logic [3:0] OFS_CONTROL       = 4'h1;
    localparam logic [3:0] OFS_PERIOD_LOW    = 4'h2;
    localparam logic [3:0] OFS_PERIOD_HIGH   = 4'h3;
    localparam logic [3:0] OFS_DUTY_LOW      = 4'h4;
    localparam logic [3:0] OFS_DUTY_HIGH     = 4'h5;
    localparam logic [3:0] OFS_DEADTIME_LOW  = 4'h6;
    localparam logic [3:0] OFS_DEADTIME_HIGH = 4'h7;

    // Enable register fields
    localparam int EN_MODULE_BIT  = 0;
    localparam int EN_MAIN_OE_BIT = 1;
    localparam int EN_PART_OE_BIT = 2;
    localparam int EN_MODE_BIT    = 3;

    // Control register fields
    localparam int CT_PRESC_LSB = 0;
    localparam int CT_POL_LSB   = 2;
    localparam int CT_FLAG_BIT  = 6;
    localparam int CT_IE_BIT    = 7;

    // High registers keep only their low nibble
    localparam logic [7:0] HIGH_MASK   = 8'h0F;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [7:0] EN_WR_MASK  = 8'h0F;
    localparam logic [7:0] CT_WR_MASK  = 8'hCF;

    // Prescaler divide-by minus one for selects 0..3
    localparam logic [6:0] DIV_1   = 7'h00;
    localparam logic [6:0] DIV_8   = 7'h07;
    localparam logic [6:0] DIV_32  = 7'h1F;
    localparam logic [6:0] DIV_128 = 7'h7F;

    localparam logic [11:0] CNT_START = 12'h001;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic [11:0] period;
        logic [11:0] duty;
        logic [11:0] deadtime;
    } timing_s;

    typedef struct packed {
        logic [7:0]  enable;
        logic [7:0]  control;
        logic [7:0]  period_low;
        logic [3:0]  period_high;
        logic [7:0]  duty_low;
        logic [3:0]  duty_high;
        logic [7:0]  deadtime_low;
        logic [3:0]  deadtime_high;
        timing_s     pend;
        timing_s     shadow;
        logic [6:0]  presc;
        logic [11:0] count;
        logic [11:0] gap;
        logic        main_act;
        logic        part_act;
        logic        prev_phase;
        logic [7:0]  rdata;
    } pwm_state_s;

endpackage

// >>> pwm_pair_tb.sv
// Testbench for the PWM pair generator
`timescale 1ns/1ns
module pwm_pair_tb;
    logic        clk, nrst, clk_en, reg_wr, reg_rd, main_output, partner_output, overflow_flag;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [15:0] m_lo, m_hi, p_lo, p_hi;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    pwm_pair uut (.clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .main_output, .partner_output, .overflow_flag);
    pwm_load load (.clk, .main_output, .partner_output, .m_lo, .m_hi, .p_lo, .p_hi);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task set12(input logic [3:0] lo, input logic [11:0] v);
        wr(lo + 4'h1, {4'h0, v[11:8]});
        wr(lo, v[7:0]);
    endtask
    initial begin
        nrst = 1'h0;
        clk_en = 1'h1;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        for (int i = 0; i < 9; i++) begin
            rd(i[3:0], d);
            chk("reset value", {8'h00, d}, 16'h0000);
        end
        for (int i = 3; i < 8; i += 2) begin
            wr(i[3:0], 8'hFF);
            rd(i[3:0], d);
            chk("high reg", {8'h00, d}, 16'h000F);
        end
        $display("test registers done");
        set12(pwm_pair_pkg::OFS_PERIOD_LOW, 12'h00A);
        set12(pwm_pair_pkg::OFS_DUTY_LOW, 12'h003);
        set12(pwm_pair_pkg::OFS_DEADTIME_LOW, 12'h006);
        rd(pwm_pair_pkg::OFS_PERIOD_LOW, d);
        chk("period low", {8'h00, d}, 16'h000A);
        wr(pwm_pair_pkg::OFS_CONTROL, 8'h08);
        wr(pwm_pair_pkg::OFS_ENABLE, 8'h0F);
        repeat (40) @(posedge clk);
        chk("main low", m_lo, 16'h0003);
        chk("main high", m_hi, 16'h0007);
        chk("partner high", p_hi, 16'h0006);
        chk("flag", {15'h0000, overflow_flag}, 16'h0001);
        wr(pwm_pair_pkg::OFS_CONTROL, 8'h0C);
        repeat (40) @(posedge clk);
        chk("partner low", p_lo, 16'h0006);
        clk_en <= 1'h0;
        wr(pwm_pair_pkg::OFS_DUTY_HIGH, 8'h05);
        clk_en <= 1'h1;
        rd(pwm_pair_pkg::OFS_DUTY_HIGH, d);
        chk("frozen write", {8'h00, d}, 16'h0000);
        $display("test independent done");
        set12(pwm_pair_pkg::OFS_PERIOD_LOW, 12'h00C);
        repeat (40) @(posedge clk);
        chk("main high", m_hi, 16'h0009);
        wr(pwm_pair_pkg::OFS_PERIOD_HIGH, 8'h01);
        repeat (40) @(posedge clk);
        chk("main high", m_hi, 16'h0009);
        wr(pwm_pair_pkg::OFS_PERIOD_HIGH, 8'h00);
        wr(pwm_pair_pkg::OFS_CONTROL, 8'h0D);
        repeat (300) @(posedge clk);
        chk("main low", m_lo, 16'h0018);
        $display("test period done");
        wr(pwm_pair_pkg::OFS_ENABLE, 8'h00);
        wr(pwm_pair_pkg::OFS_CONTROL, 8'h48);
        // dead 2 below duty 4, sum below period 12
        set12(pwm_pair_pkg::OFS_DUTY_LOW, 12'h004);
        set12(pwm_pair_pkg::OFS_DEADTIME_LOW, 12'h002);
        wr(pwm_pair_pkg::OFS_ENABLE, 8'h07);
        repeat (60) @(posedge clk);
        chk("main low", m_lo, 16'h0002);
        chk("partner high", p_hi, 16'h0006);
        wr(pwm_pair_pkg::OFS_ENABLE, 8'h00);
        wr(pwm_pair_pkg::OFS_CONTROL, 8'h08);
        #1;
        chk("pins", {13'h0000, overflow_flag, main_output, partner_output}, 16'h0002);
        $display("test complementary done");
        print_verdict();
    end
endmodule
